// File: core/pin_sync.sv
// Two flip-flop synchroniser for one asynchronous input pin.
`timescale 1ns/10ps
module pin_sync #(
  parameter logic IDLE_LEVEL = 1'b1
) (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Pin and synchronised level.
  input  wire logic pin_i,
  output logic      level_o
);

  typedef struct packed {
    logic first_stage;
    logic second_stage;
  } sync_state_s;

  sync_state_s state;
  sync_state_s next_state;

  // The first stage feeds only the second stage, to keep metastability contained.
  always_comb begin
    next_state              = state;
    next_state.first_stage  = pin_i;
    next_state.second_stage = state.first_stage;
    if (rst_i) begin
      next_state.first_stage  = IDLE_LEVEL;
      next_state.second_stage = IDLE_LEVEL;
    end
  end

  // State register.
  always_ff @(posedge clk_i) begin
    state <= next_state;
  end

  assign level_o = state.second_stage;

endmodule // pin_sync

// File: core/sleep_code_select.sv
// Chooses the third converter's target code from sleep enable and the assigned pin.
`timescale 1ns/10ps
module sleep_code_select #(
  parameter int unsigned CODE_W = 7
) (
  // Controls.
  input  wire logic              sleep_enable_i,
  input  wire logic              pin_select_i,
  input  wire logic              first_sleep_level_i,
  input  wire logic              second_sleep_level_i,
  // Codes.
  input  wire logic [CODE_W-1:0] normal_code_i,
  input  wire logic [CODE_W-1:0] sleep_code_i,
  output logic      [CODE_W-1:0] target_code_o,
  output logic                   in_sleep_o
);

  logic assigned_level;

  // Only the factory assigned pin is looked at; the other one is ignored.
  always_comb begin
    if (pin_select_i == switcher_regs_pkg::PIN_SELECT_FIRST) begin
      assigned_level = first_sleep_level_i;
    end else begin
      assigned_level = second_sleep_level_i;
    end
  end

  // Sleep applies only while enabled and the pin sits low.
  assign in_sleep_o    = (sleep_enable_i == switcher_regs_pkg::SLEEP_ENABLED) &&
                         (assigned_level != switcher_regs_pkg::PIN_IDLE_LEVEL);
  assign target_code_o = in_sleep_o ? sleep_code_i : normal_code_i;

endmodule // sleep_code_select

// File: core/switcher_voltage_regs.sv
// Wishbone register bank holding voltage codes and slew or decay choices for two converters.
`timescale 1ns/10ps

module switcher_voltage_regs #(
  parameter int unsigned ADR_W  = 12,
  parameter int unsigned CODE_W = switcher_regs_pkg::CODE_W
) (
  // Clock and reset.
  input  wire logic                                       clk_i,
  input  wire logic                                       rst_i,
  // Wishbone slave.
  input  wire logic                                       wb_cyc_i,
  input  wire logic                                       wb_stb_i,
  input  wire logic                                       wb_we_i,
  input  wire logic [ADR_W-1:0]                           wb_adr_i,
  input  wire logic [switcher_regs_pkg::WB_SEL_W-1:0]     wb_sel_i,
  input  wire logic [switcher_regs_pkg::WB_DATA_W-1:0]    wb_dat_i,
  output logic      [switcher_regs_pkg::WB_DATA_W-1:0]    wb_dat_o,
  output logic                                            wb_ack_o,
  // Factory configuration.
  input  wire switcher_regs_pkg::factory_defaults_s       factory_defaults_i,
  input  wire logic                                       factory_pin_select_i,
  // Sleep control pins, active low and asynchronous.
  input  wire logic                                       first_sleep_control_pin_i,
  input  wire logic                                       second_sleep_control_pin_i,
  // Regulation targets.
  output switcher_regs_pkg::switcher_targets_s            targets_o
);

  localparam int unsigned MSB = switcher_regs_pkg::CODE_MSB;
  localparam int unsigned LSB = switcher_regs_pkg::CODE_LSB;
  localparam int unsigned SEL = switcher_regs_pkg::SELECT_BIT;
  localparam int unsigned REG_W = switcher_regs_pkg::REG_W;

  typedef struct packed {
    logic [REG_W-1:0]                     second_control;
    logic [REG_W-1:0]                     third_decay_control;
    logic [CODE_W-1:0]                    third_voltage_code;
    logic [REG_W-1:0]                     third_sleep_control;
    logic                                 pin_select;
    logic                                 ack;
    logic [REG_W-1:0]                     read_data;
    switcher_regs_pkg::switcher_targets_s targets;
  } bank_state_s;

  bank_state_s       state;
  bank_state_s       next_state;
  logic              request;
  logic              new_request;
  logic              write_commit;
  logic [ADR_W-1:0]  addr_second_control;
  logic [ADR_W-1:0]  addr_third_decay;
  logic [ADR_W-1:0]  addr_third_code;
  logic [ADR_W-1:0]  addr_third_sleep;
  logic [REG_W-1:0]  read_value;
  logic              first_sleep_level;
  logic              second_sleep_level;
  logic [CODE_W-1:0] third_selected_code;
  logic              third_sleep_request;
  logic [CODE_W-1:0] write_code;
  logic              write_select;

  // Byte addresses of the four registers, four times the printed index.
  assign addr_second_control = ADR_W'(switcher_regs_pkg::IDX_SECOND_CONTROL)
                               << switcher_regs_pkg::IDX_LSB;
  assign addr_third_decay    = ADR_W'(switcher_regs_pkg::IDX_THIRD_DECAY_CONTROL)
                               << switcher_regs_pkg::IDX_LSB;
  assign addr_third_code     = ADR_W'(switcher_regs_pkg::IDX_THIRD_VOLTAGE_CODE)
                               << switcher_regs_pkg::IDX_LSB;
  assign addr_third_sleep    = ADR_W'(switcher_regs_pkg::IDX_THIRD_SLEEP_CONTROL)
                               << switcher_regs_pkg::IDX_LSB;

  // Bus qualifiers; a write lands at the edge where the master sees ack.
  assign request      = wb_cyc_i && wb_stb_i;
  assign new_request  = request && !state.ack;
  assign write_commit = request && state.ack && wb_we_i && wb_sel_i[0];
  assign write_code   = wb_dat_i[MSB:LSB];
  assign write_select = wb_dat_i[SEL];

  // Sleep pins come from outside, so each passes two flip-flops first.
  pin_sync #(
    .IDLE_LEVEL (switcher_regs_pkg::PIN_IDLE_LEVEL)
  ) u_first_pin_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (first_sleep_control_pin_i),
    .level_o (first_sleep_level)
  );

  pin_sync #(
    .IDLE_LEVEL (switcher_regs_pkg::PIN_IDLE_LEVEL)
  ) u_second_pin_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (second_sleep_control_pin_i),
    .level_o (second_sleep_level)
  );

  sleep_code_select #(
    .CODE_W (CODE_W)
  ) u_sleep_code_select (
    .sleep_enable_i       (state.third_sleep_control[SEL]),
    .pin_select_i         (state.pin_select),
    .first_sleep_level_i  (first_sleep_level),
    .second_sleep_level_i (second_sleep_level),
    .normal_code_i        (state.third_voltage_code),
    .sleep_code_i         (state.third_sleep_control[MSB:LSB]),
    .target_code_o        (third_selected_code),
    .in_sleep_o           (third_sleep_request)
  );

  // Read multiplexer; unmapped addresses read as zero rather than erroring.
  always_comb begin
    read_value = switcher_regs_pkg::READ_ZERO;
    if (wb_adr_i == addr_second_control) begin
      read_value = state.second_control;
    end else if (wb_adr_i == addr_third_decay) begin
      read_value = state.third_decay_control;
    end else if (wb_adr_i == addr_third_code) begin
      read_value = {state.third_voltage_code, switcher_regs_pkg::RESERVED_READ};
    end else if (wb_adr_i == addr_third_sleep) begin
      read_value = state.third_sleep_control;
    end
  end

  // Next state of the whole bank: bus handshake, register writes and targets.
  always_comb begin
    next_state     = state;
    next_state.ack = new_request;
    if (new_request && !wb_we_i) begin
      next_state.read_data = read_value;
    end
    if (write_commit) begin
      if (wb_adr_i == addr_second_control) begin
        next_state.second_control[MSB:LSB] = write_code;
        next_state.second_control[SEL] = write_select;
      end else if (wb_adr_i == addr_third_decay) begin
        next_state.third_decay_control[MSB:LSB] = write_code;
        next_state.third_decay_control[SEL] = write_select;
      end else if (wb_adr_i == addr_third_code) begin
        next_state.third_voltage_code = write_code;
      end else if (wb_adr_i == addr_third_sleep) begin
        next_state.third_sleep_control = wb_dat_i[REG_W-1:0];
      end
    end
    next_state.targets.second_switcher_voltage_code = state.second_control[MSB:LSB];
    next_state.targets.second_switcher_decay_select = state.second_control[SEL];
    next_state.targets.third_switcher_decay_select  = state.third_decay_control[SEL];
    next_state.targets.third_switcher_target_code   = third_selected_code;
    next_state.targets.third_switcher_in_sleep      = third_sleep_request;
    if (rst_i) begin
      next_state.second_control      = factory_defaults_i.second_control;
      next_state.third_decay_control = factory_defaults_i.third_decay_control;
      next_state.third_voltage_code  = factory_defaults_i.third_voltage_code[MSB:LSB];
      next_state.third_sleep_control = factory_defaults_i.third_sleep_control;
      next_state.pin_select          = factory_pin_select_i;
      next_state.ack                 = 1'b0;
      next_state.read_data           = switcher_regs_pkg::READ_ZERO;
      next_state.targets.second_switcher_voltage_code =
        factory_defaults_i.second_control[MSB:LSB];
      next_state.targets.second_switcher_decay_select =
        factory_defaults_i.second_control[SEL];
      next_state.targets.third_switcher_target_code   =
        factory_defaults_i.third_voltage_code[MSB:LSB];
      next_state.targets.third_switcher_decay_select  =
        factory_defaults_i.third_decay_control[SEL];
      next_state.targets.third_switcher_in_sleep      = 1'b0;
    end
  end

  // The only register process; reset is folded into the next state above.
  always_ff @(posedge clk_i) begin
    state <= next_state;
  end

  // Outputs; targets lag the registers by one cycle, which is harmless for a regulator.
  assign wb_ack_o  = state.ack;
  assign wb_dat_o  = {switcher_regs_pkg::UPPER_ZERO, state.read_data};
  assign targets_o = state.targets;

  // Checks on the bank's own behaviour.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic write_second;
  logic write_third_decay;
  logic write_third_sleep;
  logic read_third_code;
  logic read_second;
  logic write_third_code;
  logic addr_mapped;
  logic write_refused;
  logic assigned_level;

  // Helpers that mark a committed access to one register.
  assign write_second      = write_commit && (wb_adr_i == addr_second_control);
  assign write_third_decay = write_commit && (wb_adr_i == addr_third_decay);
  assign write_third_sleep = write_commit && (wb_adr_i == addr_third_sleep);
  assign read_third_code   = request && state.ack && !wb_we_i &&
                             (wb_adr_i == addr_third_code);
  assign read_second       = request && state.ack && !wb_we_i &&
                             (wb_adr_i == addr_second_control);
  assign write_third_code  = write_commit && (wb_adr_i == addr_third_code);

  // Refused write at its ack edge: lane 0 disabled or no register at that address.
  assign addr_mapped   = (wb_adr_i == addr_second_control) || (wb_adr_i == addr_third_decay) ||
                         (wb_adr_i == addr_third_code) || (wb_adr_i == addr_third_sleep);
  assign write_refused = request && state.ack && wb_we_i && (!wb_sel_i[0] || !addr_mapped);

  // Level of the pin that the strap selects, worked out apart from the selector module.
  assign assigned_level = (state.pin_select == switcher_regs_pkg::PIN_SELECT_FIRST) ?
                          first_sleep_level : second_sleep_level;

  a_ack_single_pulse: assert property (
    wb_ack_o |=> !wb_ack_o
  ) else $error("Ack stayed high for more than one cycle.");

  a_ack_answers_request: assert property (
    (request && !wb_ack_o) |=> wb_ack_o
  ) else $error("Ack did not follow a new request by one cycle.");

  a_ack_needs_request: assert property (
    wb_ack_o |-> $past(request)
  ) else $error("Ack rose without a request in the cycle before.");

  a_second_code_drive: assert property (
    write_second |-> ##2 (targets_o.second_switcher_voltage_code == $past(write_code, 2))
  ) else $error("Second converter target did not follow its written code.");

  a_second_decay_drive: assert property (
    write_second |-> ##2 (targets_o.second_switcher_decay_select == $past(write_select, 2))
  ) else $error("Second converter decay choice did not follow its written bit.");

  a_third_decay_drive: assert property (
    write_third_decay |-> ##2 (targets_o.third_switcher_decay_select == $past(write_select, 2))
  ) else $error("Third converter decay choice did not follow its written bit.");

  a_spare_bits_kept: assert property (
    write_third_decay |=> (state.third_decay_control[MSB:LSB] == $past(write_code))
  ) else $error("Spare bits of the third decay register were not stored.");

  a_reserved_reads_zero: assert property (
    read_third_code |-> (wb_dat_o[SEL] == switcher_regs_pkg::RESERVED_READ)
  ) else $error("Reserved bit of the third voltage code register read as one.");

  a_sleep_code_used: assert property (
    targets_o.third_switcher_in_sleep |->
      (targets_o.third_switcher_target_code == $past(state.third_sleep_control[MSB:LSB]))
  ) else $error("Sleep target differs from the stored sleep code.");

  a_sleep_needs_enable: assert property (
    !state.third_sleep_control[SEL] |=> !targets_o.third_switcher_in_sleep
  ) else $error("Third converter entered sleep while sleep was disabled.");

  a_normal_code_used: assert property (
    (!state.third_sleep_control[SEL] && $stable(state.third_voltage_code)) |=>
      (targets_o.third_switcher_target_code == $past(state.third_voltage_code))
  ) else $error("Third converter left its normal code while sleep was disabled.");

  a_pin_select_fixed: assert property (
    $stable(state.pin_select)
  ) else $error("Sleep pin assignment changed outside reset.");

  a_defaults_loaded: assert property (
    $fell(rst_i) |-> (state.second_control == $past(factory_defaults_i.second_control) &&
                      state.third_sleep_control ==
                        $past(factory_defaults_i.third_sleep_control))
  ) else $error("Registers did not hold factory defaults after reset.");

  // Register storage, read data and pin selection checks.
  a_read_second_data: assert property (
    read_second |-> (wb_dat_o[REG_W-1:0] == $past(state.second_control))
  ) else $error("Read of the second converter register returned other data.");

  a_refused_write_kept: assert property (
    write_refused |=> ((state.second_control == $past(state.second_control)) &&
                       (state.third_decay_control == $past(state.third_decay_control)) &&
                       (state.third_voltage_code == $past(state.third_voltage_code)) &&
                       (state.third_sleep_control == $past(state.third_sleep_control)))
  ) else $error("A refused write changed a register.");

  a_third_code_store: assert property (
    write_third_code |=> (state.third_voltage_code == $past(write_code))
  ) else $error("Third converter normal code was not stored.");

  a_read_code_data: assert property (
    read_third_code |-> (wb_dat_o[REG_W-1:0] ==
                         {$past(state.third_voltage_code), switcher_regs_pkg::RESERVED_READ})
  ) else $error("Read of the third voltage code register returned other data.");

  a_sleep_reg_store: assert property (
    write_third_sleep |=> (state.third_sleep_control == $past(wb_dat_i[REG_W-1:0]))
  ) else $error("Sleep code and enable were not stored.");

  a_sleep_follows_pin: assert property (
    (state.third_sleep_control[SEL] && !assigned_level) |=> targets_o.third_switcher_in_sleep
  ) else $error("Third converter ignored its assigned sleep pin.");

  a_idle_pin_normal: assert property (
    (assigned_level == switcher_regs_pkg::PIN_IDLE_LEVEL) |=> !targets_o.third_switcher_in_sleep
  ) else $error("Third converter slept while its assigned pin was idle.");

  a_defaults_codes: assert property (
    $fell(rst_i) |->
      ((state.third_decay_control == $past(factory_defaults_i.third_decay_control)) &&
       (state.third_voltage_code == $past(factory_defaults_i.third_voltage_code[MSB:LSB])))
  ) else $error("Decay and normal code registers did not hold factory defaults after reset.");

  // Cover points for the main scenarios.
  c_refused_write: cover property (write_refused);
  c_second_write: cover property (write_second);
  c_sleep_entry: cover property (!targets_o.third_switcher_in_sleep ##1
                                 targets_o.third_switcher_in_sleep);
  c_sleep_exit: cover property (targets_o.third_switcher_in_sleep ##1
                                !targets_o.third_switcher_in_sleep);
  c_sleep_write: cover property (write_third_sleep);

endmodule // switcher_voltage_regs

// File: inc/switcher_regs_pkg.sv
// Shared constants and carrier types for the switcher voltage register bank.
package switcher_regs_pkg;

  // Register and field geometry.
  localparam int unsigned REG_W      = 8;
  localparam int unsigned CODE_W     = 7;
  localparam int unsigned CODE_MSB   = 7;
  localparam int unsigned CODE_LSB   = 1;
  localparam int unsigned SELECT_BIT = 0;

  // Wishbone geometry: one 32-bit word per register, index times four is the byte address.
  localparam int unsigned WB_DATA_W = 32;
  localparam int unsigned WB_SEL_W  = 4;
  localparam int unsigned IDX_W     = 8;
  localparam int unsigned IDX_LSB   = 2;

  // Register indices as printed.
  localparam logic [IDX_W-1:0] IDX_SECOND_CONTROL      = 8'h21;
  localparam logic [IDX_W-1:0] IDX_THIRD_DECAY_CONTROL = 8'h22;
  localparam logic [IDX_W-1:0] IDX_THIRD_VOLTAGE_CODE  = 8'h23;
  localparam logic [IDX_W-1:0] IDX_THIRD_SLEEP_CONTROL = 8'h24;

  // Read fill values.
  localparam logic [REG_W-1:0]           READ_ZERO     = 8'h00;
  localparam logic [WB_DATA_W-REG_W-1:0] UPPER_ZERO    = 24'h000000;
  localparam logic                       RESERVED_READ = 1'b0;

  // Sleep control pins are active low, so the idle level means normal mode.
  localparam logic PIN_IDLE_LEVEL   = 1'b1;
  localparam logic PIN_SELECT_FIRST = 1'b0;
  localparam logic SLEEP_ENABLED    = 1'b1;

  // Factory programmed reset contents of the four registers.
  typedef struct packed {
    logic [REG_W-1:0] second_control;
    logic [REG_W-1:0] third_decay_control;
    logic [REG_W-1:0] third_voltage_code;
    logic [REG_W-1:0] third_sleep_control;
  } factory_defaults_s;

  // Regulation targets handed to the converter control loops.
  typedef struct packed {
    logic [CODE_W-1:0] second_switcher_voltage_code;
    logic              second_switcher_decay_select;
    logic [CODE_W-1:0] third_switcher_target_code;
    logic              third_switcher_decay_select;
    logic              third_switcher_in_sleep;
  } switcher_targets_s;

endpackage

// File: test/switcher_voltage_regs_test.sv
// Self-checking testbench for the switcher voltage register bank.
`timescale 1ns/10ps
module switcher_voltage_regs_test;
  // Bench clock, reset and design connections.
  logic                                  clk_i;
  logic                                  rst_i;
  logic                                  wb_cyc;
  logic                                  wb_stb;
  logic                                  wb_we;
  logic [11:0]                           wb_adr;
  logic [3:0]                            wb_sel;
  logic [31:0]                           wb_wdat;
  logic [31:0]                           wb_rdat;
  logic                                  wb_ack;
  switcher_regs_pkg::factory_defaults_s  defaults;
  logic                                  strap;
  logic                                  first_pin;
  logic                                  second_pin;
  switcher_regs_pkg::switcher_targets_s  targets;
  logic [31:0]                           rd;
  int                                    err_total;
  int                                    num_checks;

  // Design under test with its default geometry.
  switcher_voltage_regs dut (
    .clk_i                      (clk_i),
    .rst_i                      (rst_i),
    .wb_cyc_i                   (wb_cyc),
    .wb_stb_i                   (wb_stb),
    .wb_we_i                    (wb_we),
    .wb_adr_i                   (wb_adr),
    .wb_sel_i                   (wb_sel),
    .wb_dat_i                   (wb_wdat),
    .wb_dat_o                   (wb_rdat),
    .wb_ack_o                   (wb_ack),
    .factory_defaults_i         (defaults),
    .factory_pin_select_i       (strap),
    .first_sleep_control_pin_i  (first_pin),
    .second_sleep_control_pin_i (second_pin),
    .targets_o                  (targets)
  );

  // Free-running 100 MHz clock.
  always begin
    #5 clk_i = ~clk_i;
  end

  // Prints the verdict and ends the run; the only place the run stops.
  task automatic wrap_up();
    if (err_total == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One classic Wishbone cycle; the request is held until ack is sampled high.
  task automatic wb_xfer(input logic we, input logic [11:0] adr, input logic [3:0] sel,
                         input logic [31:0] wd, output logic [31:0] rdv);
    @(posedge clk_i);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= adr;
    wb_sel  <= sel;
    wb_wdat <= wd;
    // No local limit: a slave that never answers is caught by the watchdog.
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    rdv = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask

  // Byte write into lane 0 with the given lane enables.
  task automatic wr(input logic [11:0] adr, input logic [3:0] sel, input logic [7:0] d);
    wb_xfer(1'b1, adr, sel, {24'h000000, d}, rd);
  endtask

  // Reads one word and compares the whole 32 bits, so the upper zero fill is checked too.
  task automatic rd_chk(input string name, input logic [11:0] adr, input logic [7:0] exp);
    wb_xfer(1'b0, adr, 4'hf, 32'hffffff00, rd);
    check(name, rd, {24'h000000, exp});
  endtask

  // Reference model of the targets, worked out from register contents and the assigned pin.
  // Waiting four edges covers the two-flop pin sync plus the registered output stage.
  task automatic tgt(input logic [7:0] r21, input logic [7:0] r22, input logic [7:0] r23,
                     input logic [7:0] r24, input logic pin_low);
    logic sl;
    sl = r24[0] & pin_low;
    repeat (4) @(posedge clk_i);
    check("second code", {25'h0, targets.second_switcher_voltage_code}, {25'h0, r21[7:1]});
    check("second decay", {31'h0, targets.second_switcher_decay_select}, {31'h0, r21[0]});
    check("third decay", {31'h0, targets.third_switcher_decay_select}, {31'h0, r22[0]});
    check("in sleep", {31'h0, targets.third_switcher_in_sleep}, {31'h0, sl});
    check("third code", {25'h0, targets.third_switcher_target_code},
          {25'h0, sl ? r24[7:1] : r23[7:1]});
  endtask

  // Synchronous reset held for two edges while new factory contents are presented.
  task automatic do_reset(input logic [31:0] dflt, input logic st);
    @(posedge clk_i);
    rst_i    <= 1'b1;
    defaults <= dflt;
    strap    <= st;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  // Watchdog: the whole sequence needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge clk_i);
    err_total++;
    wrap_up();
  end

  // Main test sequence.
  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    {wb_cyc, wb_stb, wb_we} = 3'h0;
    wb_adr = 12'h000;
    wb_sel = 4'h0;
    wb_wdat = 32'h00000000;
    defaults = 32'h5a414581;
    strap = 1'b0;
    first_pin = 1'b1;
    second_pin = 1'b1;
    err_total = 0;
    num_checks = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    // Factory contents after reset; bit 0 of the third code register always reads zero.
    rd_chk("reg21 reset", 12'h084, 8'h5a);
    rd_chk("reg22 reset", 12'h088, 8'h41);
    rd_chk("reg23 reset", 12'h08c, 8'h44);
    rd_chk("reg24 reset", 12'h090, 8'h81);
    tgt(8'h5a, 8'h41, 8'h45, 8'h81, 1'b0);
    // Second converter code and decay choice.
    wr(12'h084, 4'h1, 8'hab);
    tgt(8'hab, 8'h41, 8'h45, 8'h81, 1'b0);
    rd_chk("reg21 write", 12'h084, 8'hab);
    // Spare bits store freely; this write also clears bit 0, the third converter's decay choice.
    wr(12'h088, 4'h1, 8'hfe);
    rd_chk("reg22 spare", 12'h088, 8'hfe);
    tgt(8'hab, 8'hfe, 8'h45, 8'h81, 1'b0);
    wr(12'h084, 4'h1, 8'h54);
    wr(12'h088, 4'h1, 8'h01);
    tgt(8'h54, 8'h01, 8'h45, 8'h81, 1'b0);
    // Reserved bit of the third code register ignores a written one.
    wr(12'h08c, 4'h1, 8'h3b);
    rd_chk("reg23 reserved", 12'h08c, 8'h3a);
    tgt(8'h54, 8'h01, 8'h3b, 8'h81, 1'b0);
    // Refused writes: lane 0 disabled, unmapped and misaligned addresses.
    wr(12'h084, 4'he, 8'hff);
    wr(12'h080, 4'hf, 8'hff);
    wr(12'h085, 4'hf, 8'hff);
    rd_chk("reg21 sel", 12'h084, 8'h54);
    rd_chk("unmapped", 12'h080, 8'h00);
    // Sleep enabled with the first pin assigned: the second pin must not matter.
    wr(12'h090, 4'h1, 8'h13);
    @(posedge clk_i);
    second_pin <= 1'b0;
    tgt(8'h54, 8'h01, 8'h3b, 8'h13, 1'b0);
    @(posedge clk_i);
    first_pin <= 1'b0;
    tgt(8'h54, 8'h01, 8'h3b, 8'h13, 1'b1);
    // Target code follows software changes of the sleep code while asleep.
    wr(12'h090, 4'h1, 8'h6b);
    tgt(8'h54, 8'h01, 8'h3b, 8'h6b, 1'b1);
    // Disabling sleep returns to the normal code even with the pin still low.
    wr(12'h090, 4'h1, 8'h6a);
    tgt(8'h54, 8'h01, 8'h3b, 8'h6a, 1'b1);
    @(posedge clk_i);
    first_pin  <= 1'b1;
    second_pin <= 1'b1;
    // Second reset in mid-run with other factory contents and the second pin assigned.
    do_reset(32'h8100ffa3, 1'b1);
    rd_chk("reg21 reset2", 12'h084, 8'h81);
    rd_chk("reg23 reset2", 12'h08c, 8'hfe);
    rd_chk("reg24 reset2", 12'h090, 8'ha3);
    tgt(8'h81, 8'h00, 8'hff, 8'ha3, 1'b0);
    @(posedge clk_i);
    first_pin <= 1'b0;
    tgt(8'h81, 8'h00, 8'hff, 8'ha3, 1'b0);
    @(posedge clk_i);
    second_pin <= 1'b0;
    tgt(8'h81, 8'h00, 8'hff, 8'ha3, 1'b1);
    @(posedge clk_i);
    second_pin <= 1'b1;
    tgt(8'h81, 8'h00, 8'hff, 8'ha3, 1'b0);
    wrap_up();
  end
endmodule // switcher_voltage_regs_test
